// ---- fpb_pkg.sv ----
// constants shared by the flash page and burst read block
package fpb_pkg;
  localparam int          CLK_PERIOD_NS       = 20;
  localparam int          RANDOM_ACCESS_NS    = 70;
  localparam int          PAGE_HIT_ACCESS_NS  = 25;
  localparam int          RANDOM_ACCESS_CYC   = (RANDOM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          PAGE_HIT_ACCESS_CYC = (PAGE_HIT_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W               = 8;
  localparam int          WORD_IDX_W          = 3;
  localparam logic [3:0]  WAIT_MIN            = 4'h2;
  localparam logic [3:0]  WAIT_MAX            = 4'h9;
  localparam logic [4:0]  CROSS_BASE          = 5'h09;
  localparam logic [15:0] DATA_RESET          = 16'h0000;

  typedef enum logic [1:0] {
    BST_IDLE   = 2'b00,
    BST_WAIT   = 2'b01,
    BST_STREAM = 2'b11,
    BST_DONE   = 2'b10
  } fpb_burst_type;
endpackage

// ---- fpb_flash_read.sv ----
// read-side logic of a 16-bit flash: page-mode async reads and clocked bursts
module fpb_flash_read #(
  parameter int ADDR_W    = 8,
  parameter int DATA_W    = 16,
  parameter int BURST_LEN = 8
) (
  input  wire logic              CLOCK_IN,       // system clock, 50 MHz
  input  wire logic              RST_B_IN,       // async reset, active low
  input  wire logic              CE_N_IN,        // chip select, active low
  input  wire logic              OE_N_IN,        // output gate, active low
  input  wire logic              ADDRESS_VALID_N_IN, // address strobe, active low
  input  wire logic [ADDR_W-1:0] ADDR_IN,        // word address
  input  wire logic              BURST_CLK_IN,   // host burst clock, sampled
  input  wire logic              CFG_SET_IN,     // configuration command done pulse
  input  wire logic [3:0]        CFG_WAIT_IN,    // initial wait count 2..9
  input  wire logic              CFG_LINEAR_IN,  // 1 linear fixed length, 0 continuous
  input  wire logic              MEM_WR_IN,      // array load strobe
  input  wire logic [ADDR_W-1:0] MEM_WADDR_IN,   // array load address
  input  wire logic [DATA_W-1:0] MEM_WDATA_IN,   // array load data
  output logic      [DATA_W-1:0] DQ_OUT,         // data pin output value
  output logic                   DQ_OE_OUT,      // data pin drive enable
  output logic                   RDY_OUT,        // ready, low while waiting
  output logic                   RDY_OE_OUT,     // ready pin drive enable
  output logic                   SYNC_MODE_OUT   // burst mode active
);
  import fpb_pkg::*;
  localparam int PAGE_W = ADDR_W - WORD_IDX_W;

  ////////////////////////////////////////////////////////////////////////////
  // array storage
  logic [DATA_W-1:0] mem [2**ADDR_W];

  always_ff @(posedge CLOCK_IN) begin
    if (MEM_WR_IN) begin
      mem[MEM_WADDR_IN] <= MEM_WDATA_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode, pin history
  logic sync_reg, sync_next;
  logic ce_prev_reg, bclk_prev_reg;
  logic bclk_rise;
  logic [3:0] wait_cfg;

  always_comb begin
    sync_next = sync_reg | CFG_SET_IN;
  end
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      sync_reg      <= 1'b0;
      ce_prev_reg   <= 1'b1;
      bclk_prev_reg <= 1'b0;
    end else begin
      sync_reg      <= sync_next;
      ce_prev_reg   <= CE_N_IN;
      bclk_prev_reg <= BURST_CLK_IN;
    end
  end

  assign bclk_rise = BURST_CLK_IN & ~bclk_prev_reg;
  // out-of-range counts are clamped into the supported span
  always_comb begin
    if (CFG_WAIT_IN < WAIT_MIN) begin
      wait_cfg = WAIT_MIN;
    end else if (CFG_WAIT_IN > WAIT_MAX) begin
      wait_cfg = WAIT_MAX;
    end else begin
      wait_cfg = CFG_WAIT_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // asynchronous page-mode access
  logic [PAGE_W-1:0] page_reg, page_next;
  logic [ADDR_W-1:0] aaddr_reg, aaddr_next, cur_addr;
  logic              page_ok_reg, page_ok_next;
  logic              avalid_reg, avalid_next;
  logic [CNT_W-1:0]  acc_reg, acc_next;
  logic              new_access;

  // with the strobe high after a pulse, the page stays and low bits track
  assign cur_addr   = ADDRESS_VALID_N_IN ? {page_reg, ADDR_IN[WORD_IDX_W-1:0]} : ADDR_IN;
  assign new_access = ~CE_N_IN & ~sync_reg & (ce_prev_reg | (cur_addr != aaddr_reg));
  always_comb begin
    page_next    = page_reg;
    aaddr_next   = aaddr_reg;
    page_ok_next = page_ok_reg;
    avalid_next  = avalid_reg;
    acc_next     = acc_reg;
    if (CE_N_IN || sync_reg) begin
      page_ok_next = 1'b0;
      avalid_next  = 1'b0;
      acc_next     = '0;
    end else if (new_access) begin
      aaddr_next  = cur_addr;
      page_next   = cur_addr[ADDR_W-1:WORD_IDX_W];
      avalid_next = 1'b0;
      if (page_ok_reg && !ce_prev_reg && cur_addr[ADDR_W-1:WORD_IDX_W] == page_reg) begin
        acc_next = CNT_W'(PAGE_HIT_ACCESS_CYC);
      end else begin
        acc_next = CNT_W'(RANDOM_ACCESS_CYC);
      end
    end else if (acc_reg != '0) begin
      acc_next = acc_reg - 1'b1;
      if (acc_reg == CNT_W'(1)) begin
        avalid_next  = 1'b1;
        page_ok_next = 1'b1;
      end
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      page_reg    <= '0;
      aaddr_reg   <= '0;
      page_ok_reg <= 1'b0;
      avalid_reg  <= 1'b0;
      acc_reg     <= '0;
    end else begin
      page_reg    <= page_next;
      aaddr_reg   <= aaddr_next;
      page_ok_reg <= page_ok_next;
      avalid_reg  <= avalid_next;
      acc_reg     <= acc_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // burst sequencer
  fpb_burst_type     st_reg, st_next;
  logic [ADDR_W-1:0] baddr_reg, baddr_next;
  logic [3:0]        wcnt_reg, wcnt_next;
  logic [4:0]        extra_reg, extra_next;
  logic              crossed_reg, crossed_next;
  logic [7:0]        words_reg, words_next;
  logic              start, pop;
  logic [4:0]        cross_sum;
  logic [ADDR_W-1:0] baddr_inc;
  logic              buf_out_valid;
  logic [DATA_W-1:0] buf_out_data;
  assign start     = sync_reg & bclk_rise & ~CE_N_IN & ~ADDRESS_VALID_N_IN;
  assign cross_sum = {2'b00, ADDR_IN[WORD_IDX_W-1:0]} + {1'b0, wait_cfg};
  assign baddr_inc = baddr_reg + 1'b1;
  assign pop       = bclk_rise & ~CE_N_IN & buf_out_valid & (wcnt_reg == '0)
                     & (st_reg == BST_WAIT || st_reg == BST_STREAM);

  always_comb begin
    st_next      = st_reg;
    baddr_next   = baddr_reg;
    wcnt_next    = wcnt_reg;
    extra_next   = extra_reg;
    crossed_next = crossed_reg;
    words_next   = words_reg;
    if (CE_N_IN) begin
      st_next = BST_IDLE;
    end else if (start) begin
      st_next      = BST_WAIT;
      baddr_next   = ADDR_IN;
      wcnt_next    = wait_cfg - 1'b1;
      extra_next   = (cross_sum > CROSS_BASE) ? cross_sum - CROSS_BASE : '0;
      crossed_next = 1'b0;
      words_next   = '0;
    end else if (bclk_rise && (st_reg == BST_WAIT || st_reg == BST_STREAM)) begin
      if (wcnt_reg != '0) begin
        wcnt_next = wcnt_reg - 1'b1;
      end else if (pop) begin
        st_next    = BST_STREAM;
        baddr_next = baddr_inc;
        words_next = words_reg + 1'b1;
        if (baddr_inc[WORD_IDX_W-1:0] == '0 && !crossed_reg) begin
          crossed_next = 1'b1;
          wcnt_next    = extra_reg[3:0];
        end
        if (CFG_LINEAR_IN && words_reg == 8'(BURST_LEN - 1)) begin
          st_next = BST_DONE;
        end
      end
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      st_reg      <= BST_IDLE;
      baddr_reg   <= '0;
      wcnt_reg    <= '0;
      extra_reg   <= '0;
      crossed_reg <= 1'b0;
      words_reg   <= '0;
    end else begin
      st_reg      <= st_next;
      baddr_reg   <= baddr_next;
      wcnt_reg    <= wcnt_next;
      extra_reg   <= extra_next;
      crossed_reg <= crossed_next;
      words_reg   <= words_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prefetch into a two-entry buffer; the burst edge drains it
  logic [ADDR_W-1:0] faddr_reg, faddr_next;
  logic [DATA_W-1:0] b0_reg, b0_next, b1_reg, b1_next;
  logic [1:0]        bcnt_reg, bcnt_next;
  logic              in_valid, in_ready, push;

  assign in_valid      = ~CE_N_IN & ~start & (st_reg == BST_WAIT || st_reg == BST_STREAM);
  assign in_ready      = (bcnt_reg != 2'h2) | pop;
  assign push          = in_valid & in_ready;
  assign buf_out_valid = bcnt_reg != 2'h0;
  assign buf_out_data  = b0_reg;

  always_comb begin
    faddr_next = faddr_reg;
    b0_next    = b0_reg;
    b1_next    = b1_reg;
    bcnt_next  = bcnt_reg;
    if (start || CE_N_IN) begin
      faddr_next = ADDR_IN; // a fresh burst flushes stale words
      bcnt_next  = 2'h0;
    end else begin
      if (push) begin
        faddr_next = faddr_reg + 1'b1;
      end
      unique case ({push, pop})
        2'b10: begin
          if (bcnt_reg == 2'h0) begin
            b0_next = mem[faddr_reg];
          end else begin
            b1_next = mem[faddr_reg];
          end
          bcnt_next = bcnt_reg + 1'b1;
        end
        2'b01: begin
          b0_next   = b1_reg;
          bcnt_next = bcnt_reg - 1'b1;
        end
        2'b11: begin
          if (bcnt_reg == 2'h1) begin
            b0_next = mem[faddr_reg];
          end else begin
            b0_next = b1_reg;
            b1_next = mem[faddr_reg];
          end
        end
        2'b00: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      faddr_reg <= '0;
      b0_reg    <= DATA_RESET;
      b1_reg    <= DATA_RESET;
      bcnt_reg  <= 2'h0;
    end else begin
      faddr_reg <= faddr_next;
      b0_reg    <= b0_next;
      b1_reg    <= b1_next;
      bcnt_reg  <= bcnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin outputs
  logic [DATA_W-1:0] dq_reg, dq_next;
  logic              dq_oe_reg, dq_oe_next;
  logic              rdy_reg, rdy_next;
  logic              rdy_oe_reg, rdy_oe_next;

  always_comb begin
    dq_next     = dq_reg;
    rdy_next    = rdy_reg;
    rdy_oe_next = ~CE_N_IN;
    dq_oe_next  = 1'b0;
    if (!sync_reg) begin
      rdy_next = 1'b1;
      if (avalid_next) begin
        dq_next = mem[aaddr_next];
      end
      dq_oe_next = ~CE_N_IN & ~OE_N_IN & avalid_next;
    end else begin
      if (start) begin
        rdy_next = 1'b0;
      end else if (pop) begin
        dq_next  = buf_out_data;
        rdy_next = 1'b1;
      end else if (bclk_rise && (st_reg == BST_WAIT || st_reg == BST_STREAM)) begin
        rdy_next = 1'b0;
      end
      dq_oe_next = ~CE_N_IN & ~OE_N_IN & (st_next == BST_STREAM || st_next == BST_DONE);
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      dq_reg     <= DATA_RESET;
      dq_oe_reg  <= 1'b0;
      rdy_reg    <= 1'b1;
      rdy_oe_reg <= 1'b0;
    end else begin
      dq_reg     <= dq_next;
      dq_oe_reg  <= dq_oe_next;
      rdy_reg    <= rdy_next;
      rdy_oe_reg <= rdy_oe_next;
    end
  end

  assign DQ_OUT        = dq_reg;
  assign DQ_OE_OUT     = dq_oe_reg;
  assign RDY_OUT       = rdy_reg;
  assign RDY_OE_OUT    = rdy_oe_reg;
  assign SYNC_MODE_OUT = sync_reg;
endmodule

// ---- fpb_flash_read_monitor.sv ----
// port assertions for the flash page and burst read block
module fpb_flash_read_monitor #(
  parameter int DATA_W = 16
) (
  input wire logic              CLOCK_IN,           // clock
  input wire logic              RST_B_IN,           // reset, active low
  input wire logic              CE_N_IN,            // select
  input wire logic              OE_N_IN,            // output gate
  input wire logic              ADDRESS_VALID_N_IN, // strobe
  input wire logic              BURST_CLK_IN,       // burst clock
  input wire logic              CFG_SET_IN,         // config pulse
  input wire logic [DATA_W-1:0] DQ_OUT,             // data
  input wire logic              DQ_OE_OUT,          // data enable
  input wire logic              RDY_OUT,            // ready
  input wire logic              RDY_OE_OUT,         // ready enable
  input wire logic              SYNC_MODE_OUT       // burst mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_B_IN);
  property p_rst_mode; $rose(RST_B_IN) |-> !SYNC_MODE_OUT && !DQ_OE_OUT; endproperty
  a_rst_mode: assert property (p_rst_mode) else $error("not async after reset");
  property p_cfg; CFG_SET_IN |-> ##[1:2] SYNC_MODE_OUT; endproperty
  a_cfg: assert property (p_cfg) else $error("config did not enter burst mode");
  property p_hold; SYNC_MODE_OUT |=> SYNC_MODE_OUT; endproperty
  a_hold: assert property (p_hold) else $error("burst mode dropped");
  property p_gate; DQ_OE_OUT |-> !$past(CE_N_IN) && !$past(OE_N_IN); endproperty
  a_gate: assert property (p_gate) else $error("data driven while not gated");
  property p_release; CE_N_IN |=> !RDY_OE_OUT && !DQ_OE_OUT; endproperty
  a_release: assert property (p_release) else $error("pins not released");
  property p_async_rdy; !SYNC_MODE_OUT |-> RDY_OUT; endproperty
  a_async_rdy: assert property (p_async_rdy) else $error("ready low in async mode");
  property p_latch;
    SYNC_MODE_OUT && !CE_N_IN && !ADDRESS_VALID_N_IN && $rose(BURST_CLK_IN) |-> ##[1:3] !RDY_OUT;
  endproperty
  a_latch: assert property (p_latch) else $error("no wait after latch");
  property p_step;
    SYNC_MODE_OUT && !CE_N_IN && !$past(CE_N_IN) && $changed(DQ_OUT) |->
      $past(BURST_CLK_IN) && !$past(BURST_CLK_IN, 2) || $past(BURST_CLK_IN, 2) && !$past(BURST_CLK_IN, 3);
  endproperty
  a_step: assert property (p_step) else $error("data changed without clock rise");
endmodule
bind fpb_flash_read fpb_flash_read_monitor #(.DATA_W(DATA_W)) i_mon (
  .CLOCK_IN(CLOCK_IN), .RST_B_IN(RST_B_IN), .CE_N_IN(CE_N_IN), .OE_N_IN(OE_N_IN),
  .ADDRESS_VALID_N_IN(ADDRESS_VALID_N_IN), .BURST_CLK_IN(BURST_CLK_IN), .CFG_SET_IN(CFG_SET_IN),
  .DQ_OUT(DQ_OUT), .DQ_OE_OUT(DQ_OE_OUT), .RDY_OUT(RDY_OUT), .RDY_OE_OUT(RDY_OE_OUT),
  .SYNC_MODE_OUT(SYNC_MODE_OUT));

// ---- fpb_host_model.sv ----
// host controller model: select, gate, strobe, address and burst clock
module fpb_host_model #(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk_in,           // system clock
  output logic                   ce_n_out,         // select
  output logic                   oe_n_out,         // output gate
  output logic                   addr_valid_n_out, // address strobe
  output logic      [ADDR_W-1:0] addr_out,         // address
  output logic                   bclk_out          // burst clock
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ce_n_out = 1'b1;
    oe_n_out = 1'b1;
    addr_valid_n_out = 1'b1;
    addr_out = '0;
    bclk_out = 1'b0;
  end
  // address held stable while the strobe stays low
  task automatic present(input logic [ADDR_W-1:0] a);
    @(posedge clk_in);
    #1;
    ce_n_out = 1'b0;
    oe_n_out = 1'b0;
    addr_valid_n_out = 1'b0;
    addr_out = a;
  endtask
  // strobe high after one pulse: page stays latched, upper lines are junk
  task automatic present_word(input logic [ADDR_W-1:0] a);
    @(posedge clk_in);
    #1;
    addr_valid_n_out = 1'b1;
    addr_out = {~a[ADDR_W-1:3], a[2:0]};
  endtask
  task automatic release_bus();
    @(posedge clk_in);
    #1;
    ce_n_out = 1'b1;
    addr_valid_n_out = 1'b1;
    addr_out = ~addr_out;
  endtask
  // first rise latches; afterwards the address lines toggle as released
  task automatic rises(input int n, input int gap);
    repeat (n) begin
      bclk_out = 1'b1;
      repeat (2) @(posedge clk_in);
      #1;
      bclk_out = 1'b0;
      addr_valid_n_out = 1'b1;
      addr_out = ~addr_out;
      repeat (2 + gap) @(posedge clk_in);
      #1;
    end
  endtask
endmodule

// ---- tb_fpb_flash_read.sv ----
// self-checking bench for the flash page and burst read block
module tb_fpb_flash_read;
  timeunit 1ns;
  timeprecision 1ps;
  import fpb_pkg::*;
  `define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_count++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
  typedef struct packed { logic neg; logic rdy; logic [15:0] d; } fpb_exp_type;
  logic        clk, rst_b, cfg_set, linear, mem_wr, chk;
  logic        ce_n, oe_n, addr_valid_n, bclk, dq_oe, rdy, rdy_oe, sync_mode;
  logic [3:0]  cfg_wait;
  logic [7:0]  addr, waddr;
  logic [15:0] wdata, dq;
  logic [15:0] mem [256];
  logic [1:0]  bh;
  fpb_exp_type exp_q[$];
  fpb_exp_type ex;
  int          err_count, tests_run, cyc, pg;
  int          cs [12] = '{65, 69, 58, 62, 63, 37, 38, 39, 30, 31, 23, 79};
  fpb_host_model #(.ADDR_W(8)) i_host (.clk_in(clk), .ce_n_out(ce_n), .oe_n_out(oe_n),
    .addr_valid_n_out(addr_valid_n), .addr_out(addr), .bclk_out(bclk));
  fpb_flash_read i_dut (.CLOCK_IN(clk), .RST_B_IN(rst_b), .CE_N_IN(ce_n), .OE_N_IN(oe_n),
    .ADDRESS_VALID_N_IN(addr_valid_n), .ADDR_IN(addr), .BURST_CLK_IN(bclk), .CFG_SET_IN(cfg_set),
    .CFG_WAIT_IN(cfg_wait), .CFG_LINEAR_IN(linear), .MEM_WR_IN(mem_wr), .MEM_WADDR_IN(waddr),
    .MEM_WDATA_IN(wdata), .DQ_OUT(dq), .DQ_OE_OUT(dq_oe), .RDY_OUT(rdy), .RDY_OE_OUT(rdy_oe),
    .SYNC_MODE_OUT(sync_mode));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    err_count += exp_q.size();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function automatic void note(logic n, logic r, logic [15:0] d);
    exp_q.push_back({n, r, d});
  endfunction
  // note a word, raise the look strobe c cycles after the address went out and look at it on the next edge
  task automatic expect_at(input int c, input logic n, input logic [15:0] d);
    note(n, 1'b0, d);
    repeat (c) @(posedge clk);
    #1 chk = 1'b1;
    @(posedge clk);
    #1 chk = 1'b0;
  endtask
  task automatic burst(input int n, input int k, input logic lin);
    int s;
    int x;
    s = 8 * $urandom_range(30, 0) + k;
    x = (k + n > 9) ? k + n - 9 : 0;
    cfg_wait = 4'(n);
    linear = lin;
    repeat (n) note(1'b0, 1'b0, 16'h0000);
    for (int i = k; i < 10; i++) begin
      if (i == 8) repeat (x) note(1'b0, 1'b0, 16'h0000);
      note(1'b0, 1'b1, mem[(lin && i > 7) ? s + 7 : s - k + i]);
    end
    i_host.present(8'(s));
    i_host.rises(n + 10 - k + x, $urandom_range(2, 0));
    i_host.release_bus();
  endtask
  //////////////////////////////////////////////////////////////////////////
  // results are taken at a look strobe or two edges after each burst clock fall
  always @(posedge clk) begin
    bh <= {bh[0], bclk};
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      $display("[ERR] %0t timeout", $time);
      complete_run();
    end else if (chk || (bh == 2'b10 && !bclk)) begin
      if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
      else begin
        ex = exp_q.pop_front();
        if (ex.neg) `CHK(dq === ex.d, 1'b0)
        else if (!chk) begin
          `CHK(rdy, ex.rdy)
          `CHK(rdy_oe, 1'b1)
          if (ex.rdy) begin
            `CHK(dq, ex.d)
            `CHK(dq_oe, 1'b1)
          end
        end else begin
          `CHK(dq, ex.d)
          `CHK(dq_oe, 1'b1)
        end
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_b, cfg_set, linear, mem_wr, chk, waddr, wdata} = '0;
    cfg_wait = 4'h2;
    void'($urandom(32'hEE1AE8C6));
    repeat (8) @(posedge clk);
    #1 rst_b = 1'b1;
    for (int i = 0; i < 256; i++) begin
      mem[i] = {8'($urandom), 8'(i)};
      mem_wr = 1'b1;
      waddr = 8'(i);
      wdata = mem[i];
      @(posedge clk);
      #1;
    end
    mem_wr = 1'b0;
    `CHK(sync_mode, 1'b0)
    pg = 8 * $urandom_range(30, 0);
    i_host.present(8'(pg));
    expect_at(RANDOM_ACCESS_CYC + 2, 1'b0, mem[pg]);
    for (int w = 7; w > 0; w--) begin
      if (w % 2 == 1) i_host.present_word(8'(pg + w));
      else i_host.present(8'(pg + w));
      expect_at(PAGE_HIT_ACCESS_CYC + 2, 1'b0, mem[pg + w]);
    end
    i_host.release_bus();
    i_host.present(8'(pg + 2));
    expect_at(PAGE_HIT_ACCESS_CYC + 2, 1'b1, mem[pg + 2]);
    expect_at(1, 1'b0, mem[pg + 2]);
    i_host.release_bus();
    $display("page reads done");
    cfg_set = 1'b1;
    @(posedge clk);
    #1 cfg_set = 1'b0;
    repeat (2) @(posedge clk);
    `CHK(sync_mode, 1'b1)
    i_host.present(8'(pg + 9));
    expect_at(RANDOM_ACCESS_CYC + 2, 1'b1, mem[pg + 9]);
    i_host.release_bus();
    for (int n = 2; n < 10; n++) burst(n, $urandom_range(7, 0), 1'b0);
    foreach (cs[i]) burst(cs[i] / 8, cs[i] % 8, 1'b0);
    burst($urandom_range(9, 2), 0, 1'b1);
    $display("bursts done");
    rst_b = 1'b0;
    @(posedge clk);
    #1 rst_b = 1'b1;
    @(posedge clk);
    `CHK(sync_mode, 1'b0)
    i_host.present(8'(pg));
    expect_at(RANDOM_ACCESS_CYC + 2, 1'b0, mem[pg]);
    i_host.release_bus();
    $display("reset test done");
    complete_run();
  end
endmodule
